// ==== pcu_consts.vh ====
// register map, field positions, reset values and codes of the pulse counter
// included by pcu_top.v; holds definitions only
`ifndef PCU_CONSTS_VH
`define PCU_CONSTS_VH

// per-unit register block: unit n starts at n * stride
`define PCU_UNIT_STRIDE 12'h020
`define PCU_OFS_MODE 3'h0
`define PCU_OFS_OP 3'h1
`define PCU_OFS_PERIOD 3'h2
`define PCU_OFS_EDGE 3'h3
`define PCU_OFS_INTEG 3'h4
`define PCU_OFS_SRCSEL 3'h5
`define PCU_OFS_GATESEL 3'h6
`define PCU_OFS_VALUE 3'h7
// global status word
`define PCU_ADDR_STATUS 12'h800

// field positions
`define PCU_EDGE_RISE 0
`define PCU_EDGE_FALL 1
`define PCU_STAT_LEVEL_LSB 0
`define PCU_STAT_LOST 8
`define PCU_STAT_AVAIL 9
`define PCU_SMP_UNIT_LSB 56
`define PCU_SMP_TS_LSB 32

// reset values
`define PCU_RST_MODE 3'h0
`define PCU_RST_OP 2'h0
`define PCU_RST_PERIOD 32'h00000064
`define PCU_RST_EDGE 2'h1
`define PCU_RST_SEL 6'h00

// run modes
`define PCU_MODE_FREE 3'h1
`define PCU_MODE_GFREE 3'h2
`define PCU_MODE_GATED 3'h3
`define PCU_MODE_TTAG 3'h4

// pair arithmetic codes
`define PCU_OP_NONE 2'h0
`define PCU_OP_ADD 2'h1
`define PCU_OP_SUB 2'h2

// source selector: 0..31 digital bits, 32..39 trigger lines
`define PCU_NUM_SRC 6'h28

// bus responses
`define PCU_RESP_OKAY 2'h0
`define PCU_RESP_SLVERR 2'h2

`endif

// ==== pcu_top.v ====
// pulse counter units with AXI4-Lite registers and a buffered sample stream
// assumes one 100 MHz clock, synchronous reset; pins are asynchronous to it
// What this block does
// - mode 1 clears the count every period window and outputs it at the end
// - mode 2 holds count and window timer cleared while the gate is low
// - mode 2 outputs only when the gate stayed high for a full period
// - mode 3 outputs the enabled-interval count when the gate falls
// - mode 4 detects a pulse, attaches its time and counts further pulses until the hold-off ends
// - op 0 leaves the output, op 1 adds the pair partner, op 2 subtracts it
// - the period sets window length in modes 1 and 2 and hold-off in mode 4
// - with rising selected a low-to-high source crossing is one event
// - with falling selected a high-to-low crossing counts; both is dual edge
// - with accumulate on, successive outputs are summed over time
// - results stream to the host and the latest one reads as a value
// - codes 0 to 31 select digital bits, 32 to 39 the trigger lines, higher codes nothing
`timescale 1ns/1ps
`include "pcu_consts.vh"

module pcu_fifo #(
  parameter W = 64,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // clock and reset
  input wire i_core_clk,
  input wire i_reset,
  // fill side
  input wire i_valid,
  output wire o_ready,
  input wire [W-1:0] i_data,
  // drain side
  output wire o_valid,
  input wire i_ready,
  output wire [W-1:0] o_data,
  output wire [AW:0] o_level
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW:0] wp_r;
  reg [AW:0] rp_r;
  localparam [AW:0] FULL_LVL = DEPTH;
  wire [AW:0] level = wp_r - rp_r;
  wire push = i_valid & o_ready;
  wire pop = o_valid & i_ready;

  assign o_ready = (level != FULL_LVL);
  assign o_valid = (level != {(AW+1){1'b0}});
  assign o_data = mem[rp_r[AW-1:0]];
  assign o_level = level;

  always @(posedge i_core_clk) begin
    if (i_reset) begin
      wp_r <= {(AW+1){1'b0}};
      rp_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_r <= wp_r + {{AW{1'b0}}, 1'b1};
      end
      if (pop) begin
        rp_r <= rp_r + {{AW{1'b0}}, 1'b1};
      end
    end
  end

  always @(posedge i_core_clk) begin
    if (push) begin
      mem[wp_r[AW-1:0]] <= i_data;
    end
  end
endmodule // pcu_fifo

module pcu_top #(
  parameter NU = 4,
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  // clock and reset
  input wire i_core_clk,
  input wire i_reset,
  // pulse sources
  input wire [31:0] i_dio,
  input wire [7:0] i_trig,
  // AXI4-Lite write
  input wire [11:0] i_s_axi_awaddr,
  input wire i_s_axi_awvalid,
  output wire o_s_axi_awready,
  input wire [31:0] i_s_axi_wdata,
  input wire [3:0] i_s_axi_wstrb,
  input wire i_s_axi_wvalid,
  output wire o_s_axi_wready,
  output wire [1:0] o_s_axi_bresp,
  output wire o_s_axi_bvalid,
  input wire i_s_axi_bready,
  // AXI4-Lite read
  input wire [11:0] i_s_axi_araddr,
  input wire i_s_axi_arvalid,
  output wire o_s_axi_arready,
  output wire [31:0] o_s_axi_rdata,
  output wire [1:0] o_s_axi_rresp,
  output wire o_s_axi_rvalid,
  input wire i_s_axi_rready,
  // sample stream
  output wire o_smp_valid,
  input wire i_smp_ready,
  output wire [63:0] o_smp_data
);
  function fsel;
    input [39:0] v;
    input [5:0] c;
    begin
      fsel = (c < `PCU_NUM_SRC) ? v[c] : 1'b0;
    end
  endfunction

  function [31:0] arith;
    input [1:0] op;
    input [31:0] a;
    input [31:0] b;
    begin
      case (op)
        `PCU_OP_ADD: arith = a + b;
        `PCU_OP_SUB: arith = a - b;
        default: arith = a;
      endcase
    end
  endfunction

  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer k;
    begin
      wmerge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          wmerge[8*k +: 8] = nw[8*k +: 8];
        end
      end
    end
  endfunction

  // synchronisers: the first stage feeds only the second
  reg [39:0] src_q1_r;
  reg [39:0] src_q2_r;
  reg [39:0] src_q3_r;
  reg [31:0] stamp_r;
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      src_q1_r <= 40'h0000000000;
      src_q2_r <= 40'h0000000000;
      src_q3_r <= 40'h0000000000;
      stamp_r <= 32'h00000000;
    end else begin
      src_q1_r <= {i_trig, i_dio};
      src_q2_r <= src_q1_r;
      src_q3_r <= src_q2_r;
      stamp_r <= stamp_r + 32'h00000001;
    end
  end

  // bus slave
  reg aw_ok_r;
  reg w_ok_r;
  reg [11:0] waddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg bvalid_r;
  reg [1:0] bresp_r;
  reg rvalid_r;
  reg [31:0] rdata_r;
  reg [1:0] rresp_r;
  reg lost_r;
  wire wr_fire = aw_ok_r & w_ok_r & ~bvalid_r;
  wire stat_wr = wr_fire & (waddr_r == `PCU_ADDR_STATUS);
  wire unit_wr_hit = ~waddr_r[11] & (waddr_r[10:5] < NU);
  wire unit_rd_hit = ~i_s_axi_araddr[11] & (i_s_axi_araddr[10:5] < NU);
  wire ar_fire = i_s_axi_arvalid & ~rvalid_r;

  assign o_s_axi_awready = ~aw_ok_r & ~bvalid_r;
  assign o_s_axi_wready = ~w_ok_r & ~bvalid_r;
  assign o_s_axi_bvalid = bvalid_r;
  assign o_s_axi_bresp = bresp_r;
  assign o_s_axi_arready = ~rvalid_r;
  assign o_s_axi_rvalid = rvalid_r;
  assign o_s_axi_rdata = rdata_r;
  assign o_s_axi_rresp = rresp_r;

  wire [32*NU-1:0] base_flat;
  wire [32*NU-1:0] rd_flat;
  wire [64*NU-1:0] pdat_flat;
  wire [NU-1:0] pend_flat;
  wire [NU-1:0] lost_flat;
  reg [NU-1:0] grant;
  reg [63:0] push_data;
  wire f_in_ready;
  wire [FIFO_AW:0] f_level;
  integer i;

  always @* begin
    grant = {NU{1'b0}};
    push_data = 64'h0000000000000000;
    for (i = NU - 1; i >= 0; i = i - 1) begin
      if (pend_flat[i] & f_in_ready) begin
        grant = {NU{1'b0}};
        grant[i] = 1'b1;
      end
    end
    for (i = 0; i < NU; i = i + 1) begin
      if (grant[i]) begin
        push_data = pdat_flat[64*i +: 64];
      end
    end
  end

  pcu_fifo #(
    .W(64),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_valid(|pend_flat),
    .o_ready(f_in_ready),
    .i_data(push_data),
    .o_valid(o_smp_valid),
    .i_ready(i_smp_ready),
    .o_data(o_smp_data),
    .o_level(f_level)
  );

  wire [31:0] stat_word = {22'h000000, o_smp_valid, lost_r,
    {(8-FIFO_AW-1){1'b0}}, f_level};

  always @(posedge i_core_clk) begin
    if (i_reset) begin
      aw_ok_r <= 1'b0;
      w_ok_r <= 1'b0;
      waddr_r <= 12'h000;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `PCU_RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= `PCU_RESP_OKAY;
      lost_r <= 1'b0;
    end else begin
      if (i_s_axi_awvalid & o_s_axi_awready) begin
        aw_ok_r <= 1'b1;
        waddr_r <= {i_s_axi_awaddr[11:2], 2'h0};
      end
      if (i_s_axi_wvalid & o_s_axi_wready) begin
        w_ok_r <= 1'b1;
        wdata_r <= i_s_axi_wdata;
        wstrb_r <= i_s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_ok_r <= 1'b0;
        w_ok_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= (unit_wr_hit | stat_wr) ? `PCU_RESP_OKAY
                                           : `PCU_RESP_SLVERR;
      end else if (bvalid_r & i_s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      if (ar_fire) begin
        rvalid_r <= 1'b1;
        if (unit_rd_hit) begin
          rdata_r <= rd_flat[32*i_s_axi_araddr[10:5] +: 32];
          rresp_r <= `PCU_RESP_OKAY;
        end else if ({i_s_axi_araddr[11:2], 2'h0} == `PCU_ADDR_STATUS) begin
          rdata_r <= stat_word;
          rresp_r <= `PCU_RESP_OKAY;
        end else begin
          rdata_r <= 32'h00000000;
          rresp_r <= `PCU_RESP_SLVERR;
        end
      end else if (rvalid_r & i_s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
      // a new loss wins over a clear in the same cycle
      if (|lost_flat) begin
        lost_r <= 1'b1;
      end else if (stat_wr & wstrb_r[1] & wdata_r[`PCU_STAT_LOST]) begin
        lost_r <= 1'b0;
      end
    end
  end

  genvar u;
  generate
    for (u = 0; u < NU; u = u + 1) begin : g_unit
      localparam [5:0] UID = u;
      localparam [7:0] UID8 = u;
      localparam [1:0] EDGE_RST = `PCU_RST_EDGE;
      reg [2:0] mode_r;
      reg [1:0] op_r;
      reg [31:0] per_r;
      reg rise_r;
      reg fall_r;
      reg integ_r;
      reg [5:0] src_sel_r;
      reg [5:0] gate_sel_r;
      reg [31:0] cnt_r;
      reg [31:0] tmr_r;
      reg [31:0] acc_r;
      reg [31:0] base_r;
      reg [31:0] ts_r;
      reg en_r;
      reg busy_r;
      reg pend_r;
      reg [63:0] pdat_r;
      reg lost_ev_r;
      reg [31:0] cnt_nxt;
      reg [31:0] tmr_nxt;
      reg [31:0] ts_nxt;
      reg en_nxt;
      reg busy_nxt;
      reg out_ev;
      reg [31:0] out_ts;
      reg [31:0] rdw;
      wire s = fsel(src_q2_r, src_sel_r);
      wire sp = fsel(src_q3_r, src_sel_r);
      wire g = fsel(src_q2_r, gate_sel_r);
      wire gp = fsel(src_q3_r, gate_sel_r);
      wire ev = (rise_r & s & ~sp) | (fall_r & ~s & sp);
      wire [31:0] sum = cnt_r + {31'h00000000, ev};
      // a period of zero behaves as one cycle
      wire wend = ({1'b0, tmr_r} + 33'h000000001) >= {1'b0, per_r};
      wire [31:0] rep = integ_r ? acc_r + sum : sum;
      wire [31:0] partner = base_flat[32*(u^1) +: 32];
      wire uw = wr_fire & unit_wr_hit & (waddr_r[10:5] == UID);
      wire cfg_clr = uw & (waddr_r[4:2] == `PCU_OFS_MODE);

      always @* begin
        cnt_nxt = sum;
        tmr_nxt = tmr_r + 32'h00000001;
        ts_nxt = ts_r;
        en_nxt = en_r;
        busy_nxt = busy_r;
        out_ev = 1'b0;
        out_ts = stamp_r;
        case (mode_r)
          `PCU_MODE_FREE: begin
            if (wend) begin
              out_ev = 1'b1;
              cnt_nxt = 32'h00000000;
              tmr_nxt = 32'h00000000;
            end
          end
          `PCU_MODE_GFREE: begin
            if (!g) begin
              cnt_nxt = 32'h00000000;
              tmr_nxt = 32'h00000000;
            end else if (wend) begin
              out_ev = 1'b1;
              cnt_nxt = 32'h00000000;
              tmr_nxt = 32'h00000000;
            end
          end
          `PCU_MODE_GATED: begin
            tmr_nxt = 32'h00000000;
            if (g & ~gp) begin
              en_nxt = 1'b1;
              cnt_nxt = 32'h00000000;
            end else if (~g & gp & en_r) begin
              en_nxt = 1'b0;
              out_ev = 1'b1;
              cnt_nxt = 32'h00000000;
            end else if (!en_r) begin
              cnt_nxt = 32'h00000000;
            end
          end
          `PCU_MODE_TTAG: begin
            out_ts = ts_r;
            if (!busy_r) begin
              tmr_nxt = 32'h00000000;
              cnt_nxt = 32'h00000000;
              if (ev) begin
                busy_nxt = 1'b1;
                cnt_nxt = 32'h00000001;
                ts_nxt = stamp_r;
              end
            end else if (wend) begin
              out_ev = 1'b1;
              busy_nxt = 1'b0;
              cnt_nxt = 32'h00000000;
              tmr_nxt = 32'h00000000;
            end
          end
          default: begin
            cnt_nxt = 32'h00000000;
            tmr_nxt = 32'h00000000;
            en_nxt = 1'b0;
            busy_nxt = 1'b0;
          end
        endcase
      end

      always @* begin
        case (i_s_axi_araddr[4:2])
          `PCU_OFS_MODE: rdw = {29'h00000000, mode_r};
          `PCU_OFS_OP: rdw = {30'h00000000, op_r};
          `PCU_OFS_PERIOD: rdw = per_r;
          `PCU_OFS_EDGE: rdw = {30'h00000000, fall_r, rise_r};
          `PCU_OFS_INTEG: rdw = {31'h00000000, integ_r};
          `PCU_OFS_SRCSEL: rdw = {26'h0000000, src_sel_r};
          `PCU_OFS_GATESEL: rdw = {26'h0000000, gate_sel_r};
          default: rdw = arith(op_r, base_r, partner);
        endcase
      end

      always @(posedge i_core_clk) begin
        if (i_reset) begin
          mode_r <= `PCU_RST_MODE;
          op_r <= `PCU_RST_OP;
          per_r <= `PCU_RST_PERIOD;
          rise_r <= EDGE_RST[`PCU_EDGE_RISE];
          fall_r <= EDGE_RST[`PCU_EDGE_FALL];
          integ_r <= 1'b0;
          src_sel_r <= `PCU_RST_SEL;
          gate_sel_r <= `PCU_RST_SEL;
        end else if (uw) begin
          case (waddr_r[4:2])
            // mode and op live in byte 0, so only that strobe matters
            `PCU_OFS_MODE: begin
              if (wstrb_r[0]) begin
                mode_r <= wdata_r[2:0];
              end
            end
            `PCU_OFS_OP: begin
              if (wstrb_r[0]) begin
                op_r <= wdata_r[1:0];
              end
            end
            `PCU_OFS_PERIOD: per_r <= wmerge(per_r, wdata_r, wstrb_r);
            `PCU_OFS_EDGE: begin
              if (wstrb_r[0]) begin
                rise_r <= wdata_r[`PCU_EDGE_RISE];
                fall_r <= wdata_r[`PCU_EDGE_FALL];
              end
            end
            `PCU_OFS_INTEG: begin
              if (wstrb_r[0]) begin
                integ_r <= wdata_r[0];
              end
            end
            `PCU_OFS_SRCSEL: begin
              if (wstrb_r[0]) begin
                src_sel_r <= wdata_r[5:0];
              end
            end
            `PCU_OFS_GATESEL: begin
              if (wstrb_r[0]) begin
                gate_sel_r <= wdata_r[5:0];
              end
            end
            default: begin
            end
          endcase
        end
      end

      always @(posedge i_core_clk) begin
        if (i_reset | cfg_clr) begin
          cnt_r <= 32'h00000000;
          tmr_r <= 32'h00000000;
          ts_r <= 32'h00000000;
          en_r <= 1'b0;
          busy_r <= 1'b0;
          acc_r <= 32'h00000000;
        end else begin
          cnt_r <= cnt_nxt;
          tmr_r <= tmr_nxt;
          ts_r <= ts_nxt;
          en_r <= en_nxt;
          busy_r <= busy_nxt;
          if (out_ev) begin
            acc_r <= integ_r ? rep : 32'h00000000;
          end
        end
      end

      // one pending sample per unit; a newer one overwrites a stalled one
      always @(posedge i_core_clk) begin
        if (i_reset) begin
          base_r <= 32'h00000000;
          pend_r <= 1'b0;
          pdat_r <= 64'h0000000000000000;
          lost_ev_r <= 1'b0;
        end else begin
          lost_ev_r <= out_ev & pend_r & ~grant[u];
          if (out_ev) begin
            base_r <= rep;
            pend_r <= 1'b1;
            pdat_r <= {UID8, out_ts[23:0], arith(op_r, rep, partner)};
          end else if (grant[u]) begin
            pend_r <= 1'b0;
          end
        end
      end

      assign base_flat[32*u +: 32] = base_r;
      assign rd_flat[32*u +: 32] = rdw;
      assign pdat_flat[64*u +: 64] = pdat_r;
      assign pend_flat[u] = pend_r;
      assign lost_flat[u] = lost_ev_r;
    end
  endgenerate
endmodule // pcu_top

// ==== pcu_chk_sva.sv ====
// checker for pcu_top: bus answers and the sample stream
// assumes i_core_clk and a synchronous active-high i_reset
`timescale 1ns/1ps
module pcu_chk (
  // clock and reset
  input wire i_core_clk,
  input wire i_reset,
  // bus handshakes
  input wire i_s_axi_awvalid,
  input wire o_s_axi_awready,
  input wire i_s_axi_wvalid,
  input wire o_s_axi_wready,
  input wire [1:0] o_s_axi_bresp,
  input wire o_s_axi_bvalid,
  input wire i_s_axi_bready,
  input wire i_s_axi_arvalid,
  input wire o_s_axi_arready,
  input wire [31:0] o_s_axi_rdata,
  input wire [1:0] o_s_axi_rresp,
  input wire o_s_axi_rvalid,
  input wire i_s_axi_rready,
  // sample stream
  input wire o_smp_valid,
  input wire i_smp_ready,
  input wire [63:0] o_smp_data
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  sequence s_ar_take;
    i_s_axi_arvalid && o_s_axi_arready;
  endsequence
  sequence s_wr_take;
    i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
  endsequence
  AST_RD_LAT: assert property (s_ar_take |=> o_s_axi_rvalid)
    else $error("read answer not one cycle after request");
  AST_RD_HOLD: assert property (o_s_axi_rvalid && !i_s_axi_rready |=>
    o_s_axi_rvalid && $stable(o_s_axi_rdata) && $stable(o_s_axi_rresp))
    else $error("read answer changed before taken");
  AST_RD_DONE: assert property (o_s_axi_rvalid && i_s_axi_rready |=>
    !o_s_axi_rvalid) else $error("read answer not released");
  AST_AR_BUSY: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
    else $error("read request accepted while answer pending");
  // both channels are held one cycle before the answer is launched
  AST_WR_LAT: assert property (s_wr_take |-> ##2 o_s_axi_bvalid)
    else $error("write answer not two cycles after request");
  AST_WR_HOLD: assert property (o_s_axi_bvalid && !i_s_axi_bready |=>
    o_s_axi_bvalid && $stable(o_s_axi_bresp))
    else $error("write answer changed before taken");
  AST_WR_BUSY: assert property (o_s_axi_bvalid |->
    !o_s_axi_awready && !o_s_axi_wready)
    else $error("write accepted while answer pending");
  AST_SMP_HOLD: assert property (o_smp_valid && !i_smp_ready |=>
    o_smp_valid && $stable(o_smp_data))
    else $error("sample word changed before taken");
endmodule // pcu_chk

bind pcu_top pcu_chk u_chk (.i_core_clk, .i_reset, .i_s_axi_awvalid,
  .o_s_axi_awready, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp,
  .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_arvalid, .o_s_axi_arready,
  .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready,
  .o_smp_valid, .i_smp_ready, .o_smp_data);

// ==== pcu_src_model.sv ====
// pulse sources: digital bits 0..31 and trigger lines as codes 32..39
// assumes tasks are called just after a rising edge of i_core_clk
`timescale 1ns/1ps
module pcu_src_model (
  // clock
  input wire i_core_clk,
  // pulse lines
  output wire [31:0] o_dio,
  output wire [7:0] o_trig
);
  // idle lines rest low; each level lasts 3 cycles so the sync sees it
  reg [39:0] lines_r = 40'h0;
  assign o_dio = lines_r[31:0];
  assign o_trig = lines_r[39:32];
  task automatic pulse(input int b, input int n);
    repeat (n) begin
      lines_r[b] <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      lines_r[b] <= 1'b0;
      repeat (3) @(posedge i_core_clk);
    end
  endtask
  task automatic level(input int b, input bit v);
    lines_r[b] <= v;
    @(posedge i_core_clk);
  endtask
endmodule // pcu_src_model

// ==== pulse_counter_unit_tb.sv ====
// self-checking bench for pcu_top: register bus, run modes, stream fifo
// assumes pcu_top defaults (4 units, fifo of 8) and the source model
`timescale 1ns/1ps
module pulse_counter_unit_tb;
  reg i_core_clk = 1'b0;
  reg i_reset = 1'b1;
  reg [11:0] awaddr = 12'h000, araddr = 12'h000;
  reg [31:0] wdata = 32'h0;
  reg [3:0] wstrb = 4'h0;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  reg arvalid = 1'b0, rready = 1'b0, smp_ready = 1'b1;
  wire awready, wready, bvalid, arready, rvalid, smp_valid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata, dio;
  wire [7:0] trig;
  wire [63:0] smp_data;
  int error_cnt = 0, n_compared = 0, k, e;
  int wc[4], sm[4], tl[4], tp[4];
  int ops[3] = '{5, 7, 3};
  int rst_tab[8] = '{0, 0, 100, 1, 0, 0, 0, 0};
  always #5 i_core_clk = ~i_core_clk;
  pcu_src_model src (.i_core_clk(i_core_clk), .o_dio(dio), .o_trig(trig));
  pcu_top DUT (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_dio(dio),
    .i_trig(trig), .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
    .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
    .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
    .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
    .i_s_axi_rready(rready), .o_smp_valid(smp_valid),
    .i_smp_ready(smp_ready), .o_smp_data(smp_data));
  // stream sink: words and sums per unit
  always @(posedge i_core_clk) begin
    if (smp_valid === 1'b1 && smp_ready) begin
      wc[smp_data[57:56]] <= wc[smp_data[57:56]] + 1;
      sm[smp_data[57:56]] <= sm[smp_data[57:56]] + smp_data[31:0];
      tl[smp_data[57:56]] <= smp_data[55:32];
      tp[smp_data[57:56]] <= tl[smp_data[57:56]];
    end
  end
  task tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input [63:0] got, input [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task timeout;
    error_cnt++;
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, 0, 1);
    tally_and_finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  task clr;
    foreach (wc[i]) wc[i] = 0;
    foreach (sm[i]) sm[i] = 0;
  endtask
  task automatic wr(input [11:0] a, input [31:0] d, input [3:0] s,
                    input [1:0] er);
    bit ad, wd;
    ad = 0;
    wd = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    repeat (50) begin
      @(posedge i_core_clk);
      if (bvalid === 1'b1) begin
        chk(bresp, er);
        bready <= 1'b0;
        @(posedge i_core_clk);
        return;
      end
      if (!ad && awready === 1'b1) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end
    timeout;
  endtask
  task automatic rd(input [11:0] a, input [31:0] ed, input [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    repeat (50) begin
      @(posedge i_core_clk);
      if (rvalid === 1'b1) begin
        chk(rdata, ed);
        chk(rresp, er);
        rready <= 1'b0;
        @(posedge i_core_clk);
        return;
      end
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end
    timeout;
  endtask
  // mode written last since a mode write clears the counting state
  task cfg(input [11:0] u, input [31:0] md, pd, ed, sr, gt);
    wr(u * 12'h020 + 12'h008, pd, 4'hF, 2'h0);
    wr(u * 12'h020 + 12'h00C, ed, 4'hF, 2'h0);
    wr(u * 12'h020 + 12'h014, sr, 4'hF, 2'h0);
    wr(u * 12'h020 + 12'h018, gt, 4'hF, 2'h0);
    wr(u * 12'h020, md, 4'hF, 2'h0);
  endtask
  initial begin
    repeat (6) @(posedge i_core_clk);
    i_reset <= 1'b0;
    @(posedge i_core_clk);
    for (k = 0; k < 8; k++) rd(k * 4, rst_tab[k], 2'h0);
    wr(12'h008, 32'h00001234, 4'hF, 2'h0);
    wr(12'h008, 32'hAABBCCDD, 4'h1, 2'h0);
    rd(12'h008, 32'h000012DD, 2'h0);
    wr(12'h01C, 32'h00000005, 4'hF, 2'h0);
    rd(12'h01C, 32'h00000000, 2'h0);
    wr(12'h7F0, 32'h00000001, 4'hF, 2'h2);
    rd(12'h7F0, 32'h00000000, 2'h2);
    // both edges count twice per pulse; synced so each edge counts once
    for (e = 1; e < 4; e++) begin
      clr;
      cfg(0, 1, 20, e, 0, 0);
      src.pulse(0, 4);
      tick(60);
      wr(12'h000, 0, 4'hF, 2'h0);
      tick(5);
      chk(sm[0], (e == 3) ? 8 : 4);
    end
    // gated free running: short gates, even back to back, give nothing
    clr;
    cfg(0, 2, 20, 1, 0, 1);
    repeat (2) begin
      src.level(1, 1);
      src.pulse(0, 2);
      src.level(1, 0);
      tick(3);
    end
    tick(10);
    chk(wc[0], 0);
    src.level(1, 1);
    tick(50);
    src.level(1, 0);
    tick(10);
    chk(wc[0], 2);
    // gated: unit 1 counts a trigger line, pulses outside the gate ignored
    clr;
    cfg(0, 3, 20, 1, 0, 1);
    cfg(1, 3, 20, 1, 32, 1);
    src.pulse(0, 2);
    src.level(1, 1);
    tick(4);
    src.pulse(0, 5);
    src.pulse(32, 2);
    src.level(1, 0);
    src.pulse(0, 2);
    tick(10);
    chk(wc[0], 1);
    chk(sm[0], 5);
    chk(sm[1], 2);
    for (k = 0; k < 3; k++) begin
      wr(12'h004, k, 4'hF, 2'h0);
      rd(12'h01C, ops[k], 2'h0);
    end
    wr(12'h004, 0, 4'hF, 2'h0);
    wr(12'h010, 1, 4'hF, 2'h0);
    wr(12'h000, 3, 4'hF, 2'h0);
    for (k = 3; k < 5; k++) begin
      src.level(1, 1);
      tick(4);
      src.pulse(0, k);
      src.level(1, 0);
      tick(6);
    end
    rd(12'h01C, 7, 2'h0);
    wr(12'h010, 0, 4'hF, 2'h0);
    // time tagging: a burst inside one hold-off is reported as one word
    clr;
    cfg(0, 4, 30, 1, 0, 0);
    src.pulse(0, 3);
    tick(40);
    src.pulse(0, 1);
    tick(40);
    chk(wc[0], 2);
    chk(sm[0], 4);
    // the two tagged pulses rose 58 cycles apart at the pin
    chk(tl[0] - tp[0], 58);
    // fifo fills with the sink stalled, then drains empty
    smp_ready <= 1'b0;
    cfg(0, 1, 2, 1, 0, 0);
    tick(40);
    rd(12'h800, 32'h00000308, 2'h0);
    wr(12'h000, 0, 4'hF, 2'h0);
    wr(12'h800, 32'h00000100, 4'h2, 2'h0);
    rd(12'h800, 32'h00000208, 2'h0);
    smp_ready <= 1'b1;
    tick(30);
    rd(12'h800, 32'h00000000, 2'h0);
    tally_and_finish;
  end
endmodule // pulse_counter_unit_tb
